// >>> verilog/ea_pkg.sv
package ea_pkg;
  // Address and displacement field widths
  localparam int ADDR_W = 32;
  localparam int DISP4_W = 4;
  localparam int DISP8_W = 8;
  localparam int DISP12_W = 12;
  // Scale shift amounts per operand size
  localparam logic [1:0] SHIFT_BYTE = 2'h0;
  localparam logic [1:0] SHIFT_WORD = 2'h1;
  localparam logic [1:0] SHIFT_LONG = 2'h2;
  // Longword PC mask
  localparam logic [31:0] PC_LONG_MASK = 32'hfffffffc;

  // Operand size
  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_LONG
  } op_size_t;

  // Addressing / operand modes
  typedef enum logic [3:0] {
    MODE_REG_DIRECT,
    MODE_REG_INDIRECT,
    MODE_POST_INC,
    MODE_PRE_DEC,
    MODE_REG_DISP4,
    MODE_INDEX_REG,
    MODE_GLOBAL_DISP8,
    MODE_INDEX_GLOBAL,
    MODE_PC_DISP8,
    MODE_BRANCH8,
    MODE_BRANCH12,
    MODE_BRANCH_REG,
    MODE_IMM_ZERO,
    MODE_IMM_SIGN,
    MODE_IMM_TRAP
  } ea_mode_t;
endpackage

// >>> verilog/ea_req_if.sv
`timescale 1ns/1ps
// Operands handed from the top to the address adder
interface ea_req_if;
  logic [31:0] addend_a;
  logic [31:0] addend_b;
  logic [31:0] sum;
  modport user (output addend_a, output addend_b, input sum);
  modport adder (input addend_a, input addend_b, output sum);
endinterface

// >>> verilog/ea_adder.sv
`timescale 1ns/1ps
// 32-bit wrapping adder shared by every address form but register indirect
module ea_adder (
  ea_req_if.adder bus
);
  import ea_pkg::*;
  // Carry out of bit 31 is dropped on purpose
  assign bus.sum = bus.addend_a + bus.addend_b;
endmodule // ea_adder

// >>> verilog/cpu_effective_address_unit.sv
`timescale 1ns/1ps
module cpu_effective_address_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Decoded instruction
  input wire logic req_valid,
  input wire ea_pkg::ea_mode_t mode,
  input wire ea_pkg::op_size_t op_size,
  input wire logic [11:0] disp_field,
  // Register sources
  input wire logic [31:0] general_register_n,
  input wire logic [31:0] index_register_zero,
  input wire logic [31:0] global_base_register,
  input wire logic [31:0] program_counter,
  // Results
  output logic result_valid,
  output logic [31:0] address,
  output logic address_valid,
  output logic [31:0] operand,
  output logic operand_valid,
  output logic [31:0] writeback_value,
  output logic writeback_en
);
  import ea_pkg::*;

  // ***********************************
  // Operand formation
  // ***********************************
  ea_req_if add_if ();
  logic [1:0] size_shift;
  logic [31:0] size_step;
  logic [31:0] disp4_zx;
  logic [31:0] disp8_zx;
  logic [31:0] disp8_sx;
  logic [31:0] disp12_sx;

  // Size to scale shift
  always_comb begin
    case (op_size)
      SIZE_WORD: size_shift = SHIFT_WORD;
      SIZE_LONG: size_shift = SHIFT_LONG;
      default: size_shift = SHIFT_BYTE;
    endcase
  end

  // 1, 2 or 4 step for auto-modify
  assign size_step = 32'h1 << size_shift;
  assign disp4_zx = {28'h0, disp_field[DISP4_W-1:0]};
  assign disp8_zx = {24'h0, disp_field[DISP8_W-1:0]};
  assign disp8_sx = {{24{disp_field[DISP8_W-1]}},
                     disp_field[DISP8_W-1:0]};
  assign disp12_sx = {{20{disp_field[DISP12_W-1]}},
                      disp_field[DISP12_W-1:0]};

  // Addend selection; one adder serves every address mode but register indirect to save area
  always_comb begin
    add_if.addend_a = general_register_n;
    add_if.addend_b = 32'h0;
    case (mode)
      MODE_POST_INC: add_if.addend_b = size_step;
      MODE_PRE_DEC: add_if.addend_b = -size_step;
      MODE_REG_DISP4:
        add_if.addend_b = disp4_zx << size_shift;
      MODE_INDEX_REG: add_if.addend_b = index_register_zero;
      MODE_INDEX_GLOBAL: begin
        add_if.addend_a = global_base_register;
        add_if.addend_b = index_register_zero;
      end
      MODE_GLOBAL_DISP8: begin
        add_if.addend_a = global_base_register;
        add_if.addend_b = disp8_zx << size_shift;
      end
      MODE_PC_DISP8: begin
        // Byte size is not legal here; treated as word
        if (op_size == SIZE_LONG) begin
          add_if.addend_a = program_counter & PC_LONG_MASK;
          add_if.addend_b = disp8_zx << SHIFT_LONG;
        end else begin
          add_if.addend_a = program_counter;
          add_if.addend_b = disp8_zx << SHIFT_WORD;
        end
      end
      MODE_BRANCH8: begin
        add_if.addend_a = program_counter;
        add_if.addend_b = disp8_sx << SHIFT_WORD;
      end
      MODE_BRANCH12: begin
        add_if.addend_a = program_counter;
        add_if.addend_b = disp12_sx << SHIFT_WORD;
      end
      MODE_BRANCH_REG: begin
        add_if.addend_a = program_counter;
        add_if.addend_b = general_register_n;
      end
      default: begin
        add_if.addend_a = general_register_n;
        add_if.addend_b = 32'h0;
      end
    endcase
  end

  ea_adder u_adder (
    .bus(add_if.adder)
  );

  // ***********************************
  // Registered results
  // ***********************************
  logic [31:0] address_next;
  logic [31:0] operand_next;
  logic addr_v_next;
  logic oper_v_next;
  logic wb_next;

  // Result steering per mode
  always_comb begin
    address_next = 32'h0;
    operand_next = 32'h0;
    addr_v_next = 1'b0;
    oper_v_next = 1'b0;
    wb_next = 1'b0;
    case (mode)
      MODE_REG_DIRECT: begin
        operand_next = general_register_n;
        oper_v_next = 1'b1;
      end
      MODE_REG_INDIRECT: begin
        address_next = general_register_n;
        addr_v_next = 1'b1;
      end
      MODE_POST_INC: begin
        address_next = general_register_n;
        addr_v_next = 1'b1;
        wb_next = 1'b1;
      end
      MODE_PRE_DEC: begin
        address_next = add_if.sum;
        addr_v_next = 1'b1;
        wb_next = 1'b1;
      end
      MODE_IMM_ZERO: begin
        operand_next = disp8_zx;
        oper_v_next = 1'b1;
      end
      MODE_IMM_SIGN: begin
        operand_next = disp8_sx;
        oper_v_next = 1'b1;
      end
      MODE_IMM_TRAP: begin
        operand_next = disp8_zx << SHIFT_LONG;
        oper_v_next = 1'b1;
      end
      default: begin
        address_next = add_if.sum;
        addr_v_next = 1'b1;
      end
    endcase
  end

  // Output flops; results are one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_valid <= 1'b0;
      address <= 32'h0;
      address_valid <= 1'b0;
      operand <= 32'h0;
      operand_valid <= 1'b0;
      writeback_value <= 32'h0;
      writeback_en <= 1'b0;
    end else begin
      result_valid <= req_valid;
      address <= address_next;
      address_valid <= req_valid & addr_v_next;
      operand <= operand_next;
      operand_valid <= req_valid & oper_v_next;
      writeback_value <= add_if.sum;
      writeback_en <= req_valid & wb_next;
    end
  end

  // ***********************************
  // Checks
  // ***********************************
  property p_direct;
    @(posedge clk) disable iff (sys_rst)
    req_valid && mode == MODE_REG_DIRECT |=> operand_valid && !address_valid
      && operand == $past(general_register_n);
  endproperty
  a_direct: assert property (p_direct) else $error("direct bad");

  property p_indirect;
    @(posedge clk) disable iff (sys_rst)
    req_valid && mode == MODE_REG_INDIRECT |=> !writeback_en
      && address == $past(general_register_n);
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect bad");

  property p_postinc;
    @(posedge clk) disable iff (sys_rst)
    req_valid && mode == MODE_POST_INC && op_size == SIZE_LONG |=>
      writeback_en && writeback_value == address + 32'h4;
  endproperty
  a_postinc: assert property (p_postinc)
    else $error("postinc bad");

  property p_predec;
    @(posedge clk) disable iff (sys_rst)
    req_valid && mode == MODE_PRE_DEC |=> writeback_en
      && address == writeback_value
      && address == $past(general_register_n) - (32'h1 << $past(op_size));
  endproperty
  a_predec: assert property (p_predec) else $error("predec bad");

  property p_disp4;
    @(posedge clk) disable iff (sys_rst)
    req_valid && mode == MODE_REG_DISP4 && op_size == SIZE_WORD |=>
      address == $past(general_register_n)
      + {27'h0, $past(disp_field[3:0]), 1'b0};
  endproperty
  a_disp4: assert property (p_disp4) else $error("disp4 bad");

  property p_pclong;
    @(posedge clk) disable iff (sys_rst)
    req_valid && mode == MODE_PC_DISP8 && op_size == SIZE_LONG |=>
      address[1:0] == 2'h0;
  endproperty
  a_pclong: assert property (p_pclong)
    else $error("pc long bad");

  property p_br12;
    @(posedge clk) disable iff (sys_rst)
    req_valid && mode == MODE_BRANCH12 |=>
      address == $past(program_counter)
      + {{19{$past(disp_field[11])}}, $past(disp_field), 1'b0};
  endproperty
  a_br12: assert property (p_br12) else $error("branch12 bad");

  property p_trap;
    @(posedge clk) disable iff (sys_rst)
    req_valid && mode == MODE_IMM_TRAP |=> operand[1:0] == 2'h0
      && operand[31:10] == 22'h0;
  endproperty
  a_trap: assert property (p_trap) else $error("trap bad");
endmodule // cpu_effective_address_unit

// >>> sim/ea_source_model.sv
`timescale 1ns/1ps
// Decoder and register file stand-in on the request side
module ea_source_model (
  // Clock
  input wire logic clk,
  // Decoded instruction
  output logic req_valid,
  output ea_pkg::ea_mode_t mode,
  output ea_pkg::op_size_t op_size,
  output logic [11:0] disp_field,
  // Register sources
  output logic [31:0] general_register_n,
  output logic [31:0] index_register_zero,
  output logic [31:0] global_base_register,
  output logic [31:0] program_counter
);
  import ea_pkg::*;

  // Quiet values at time zero
  initial begin
    req_valid = 1'b0;
    mode = MODE_REG_DIRECT;
    op_size = SIZE_BYTE;
    disp_field = 12'h0;
    general_register_n = 32'h0;
    index_register_zero = 32'h0;
    global_base_register = 32'h0;
    program_counter = 32'h0;
  end

  // One request per edge, so calls in a row run back to back
  task automatic issue(input ea_mode_t m, input op_size_t s,
                       input logic [11:0] d, input logic [31:0] gen_n,
                       input logic [31:0] idx_zero, input logic [31:0] glob,
                       input logic [31:0] pc);
    @(posedge clk);
    req_valid <= 1'b1;
    mode <= m;
    op_size <= s;
    disp_field <= d;
    general_register_n <= gen_n;
    index_register_zero <= idx_zero;
    global_base_register <= glob;
    program_counter <= pc;
  endtask

  // Stale disp_field and general_register_n flip when idle so nothing leans on those held values
  task automatic idle();
    @(posedge clk);
    req_valid <= 1'b0;
    disp_field <= ~disp_field;
    general_register_n <= ~general_register_n;
  endtask
endmodule // ea_source_model

// >>> sim/test_cpu_effective_address_unit.sv
`timescale 1ns/1ps
module test_cpu_effective_address_unit;
  import ea_pkg::*;
  typedef struct {
    logic [31:0] a, op, wb;
    logic av, ov, we;
    time t;
  } exp_t;
  logic clk, sys_rst, req_valid, result_valid, address_valid;
  logic operand_valid, writeback_en;
  ea_mode_t mode;
  op_size_t op_size;
  logic [11:0] disp_field;
  logic [31:0] gen_n, idx_zero, glob_base, pc, address, operand;
  logic [31:0] writeback_value;
  exp_t exp_q[$];
  exp_t cur;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  // ****************
  // Instances
  // ****************
  ea_source_model ea_source_model_inst (.clk(clk), .req_valid(req_valid),
    .mode(mode), .op_size(op_size), .disp_field(disp_field),
    .general_register_n(gen_n), .index_register_zero(idx_zero),
    .global_base_register(glob_base), .program_counter(pc));
  cpu_effective_address_unit cpu_effective_address_unit_inst (.clk(clk),
    .sys_rst(sys_rst), .req_valid(req_valid), .mode(mode),
    .op_size(op_size), .disp_field(disp_field),
    .general_register_n(gen_n), .index_register_zero(idx_zero),
    .global_base_register(glob_base), .program_counter(pc),
    .result_valid(result_valid), .address(address),
    .address_valid(address_valid), .operand(operand),
    .operand_valid(operand_valid), .writeback_value(writeback_value),
    .writeback_en(writeback_en));

  // ****************
  // Helpers
  // ****************
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reference result for one request
  function automatic exp_t model(ea_mode_t m, op_size_t s, logic [11:0] d,
      logic [31:0] n, logic [31:0] z, logic [31:0] g, logic [31:0] p);
    exp_t e;
    logic [31:0] sc;
    e = '{a: 32'h0, op: 32'h0, wb: 32'h0, av: 1'b1, ov: 1'b0, we: 1'b0,
          t: $time};
    sc = 32'h1 << s;
    case (m)
      MODE_REG_DIRECT: begin
        e.av = 1'b0;
        e.ov = 1'b1;
        e.op = n;
      end
      MODE_REG_INDIRECT: e.a = n;
      MODE_POST_INC: begin
        e.a = n;
        e.we = 1'b1;
        e.wb = n + sc;
      end
      MODE_PRE_DEC: begin
        e.a = n - sc;
        e.we = 1'b1;
        e.wb = n - sc;
      end
      MODE_REG_DISP4: e.a = n + {28'h0, d[3:0]} * sc;
      MODE_INDEX_REG: e.a = n + z;
      MODE_GLOBAL_DISP8: e.a = g + {24'h0, d[7:0]} * sc;
      MODE_INDEX_GLOBAL: e.a = g + z;
      MODE_PC_DISP8: e.a = (s == SIZE_LONG) ? (p & 32'hfffffffc) +
        {22'h0, d[7:0], 2'h0} : p + {23'h0, d[7:0], 1'h0};
      MODE_BRANCH8: e.a = p + {{23{d[7]}}, d[7:0], 1'h0};
      MODE_BRANCH12: e.a = p + {{19{d[11]}}, d, 1'h0};
      MODE_BRANCH_REG: e.a = p + n;
      MODE_IMM_ZERO: e.op = {24'h0, d[7:0]};
      MODE_IMM_SIGN: e.op = {{24{d[7]}}, d[7:0]};
      default: e.op = {22'h0, d[7:0], 2'h0};
    endcase
    if (m >= MODE_IMM_ZERO) begin
      e.av = 1'b0;
      e.ov = 1'b1;
    end
    return e;
  endfunction

  // Rounds 0 and 1 pin wrap and sign edges, the rest are random
  task automatic send(int r, ea_mode_t m, op_size_t s);
    logic [31:0] v[4];
    logic [11:0] d;
    foreach (v[i]) v[i] = $urandom();
    d = 12'($urandom());
    if (r == 0) begin
      v = '{32'hffffffff, 32'h1, 32'hfffffffe, 32'hffffffff};
      d = 12'hfff;
    end
    if (r == 1) begin
      v = '{32'h0, 32'h0, 32'h0, 32'h2};
      d = 12'h880;
    end
    ea_source_model_inst.issue(m, s, d, v[0], v[1], v[2], v[3]);
    exp_q.push_back(model(m, s, d, v[0], v[1], v[2], v[3]));
  endtask

  // ****************
  // Clock, watchdog and result checker
  // ****************
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Budget is generous: roughly 550 cycles of traffic
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // Results must land exactly one cycle after the request is taken
  always @(posedge clk) begin
    if (result_valid !== 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("result_valid", 32'h0, {31'h0, result_valid});
      end else begin
        cur = exp_q.pop_front();
        chk("latency", 32'h1, {31'h0, ($time - cur.t) == 80});
        chk("address_valid", 32'(cur.av), 32'(address_valid));
        chk("operand_valid", 32'(cur.ov), 32'(operand_valid));
        chk("writeback_en", 32'(cur.we), 32'(writeback_en));
        if (cur.av) chk("address", cur.a, address);
        if (cur.ov) chk("operand", cur.op, operand);
        if (cur.we) chk("writeback_value", cur.wb, writeback_value);
      end
    end else if (exp_q.size() > 0 && $time - exp_q[0].t >= 80) begin
      chk("result_valid", 32'h1, 32'h0);
      void'(exp_q.pop_front());
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    sys_rst = 1'b1;
    void'($urandom(32'h96300474));
    repeat (3) @(posedge clk);
    chk("reset_result_valid", 32'h0, {31'h0, result_valid});
    chk("reset_address", 32'h0, address);
    sys_rst <= 1'b0;
    for (int r = 0; r < 12; r++) begin
      for (int m = 0; m < 15; m++) begin
        for (int s = 0; s < 3; s++) begin
          send(r, ea_mode_t'(m), op_size_t'(s));
        end
      end
      ea_source_model_inst.idle();
    end
    repeat (3) @(posedge clk);
    chk("queue_left", 32'h0, exp_q.size());
    tally_and_finish();
  end
endmodule // test_cpu_effective_address_unit
